// file: dv/rcp_host_model.sv
// Host microcontroller model driving the serial clock and the data pin.
`timescale 1ns/1ps
module rcp_host_model
    import rcp_pkg::*;
#(
    parameter int HALF_NS = 40
) (
    output logic       sclk_o,
    output logic       pin_o,
    output logic       pin_oe_o,
    output logic [2:0] pick_mute_o
);
    // both bandwidth picks and mute held high while programming
    assign pick_mute_o = 3'h7;

    initial begin
        sclk_o   = 1'b0;
        pin_o    = 1'b0;
        pin_oe_o = 1'b0;
    end

    task automatic phase(input logic c, input logic d);
        sclk_o = c;
        pin_o  = d;
        #(HALF_NS);
    endtask

    // low n bits of w, msb first; clock stands low outside the frame
    task automatic send(input logic [CFG_W-1:0] w, input int n);
        #3;
        pin_oe_o = 1'b1;
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
        for (int i = n - 1; i >= 0; i--) begin
            phase(1'b0, w[i]);
            phase(1'b1, w[i]);
        end
        // extra rising edge with data low precedes the stop pulse
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b0);
        pin_oe_o = 1'b0;
    endtask
endmodule

// file: dv/tb.sv
// Self-checking bench of the receiver config port against a host model.
`timescale 1ns/1ps
module tb;
    import rcp_pkg::*;
    localparam int STARTUP = 50;

    logic             ref_clk;
    logic             reset;
    logic             sclk;
    logic             host_pin;
    logic             host_oe;
    logic             flip_q = 1'b0;
    wire              din;
    logic             dout;
    logic             dout_oe;
    logic             pdown;
    logic             demod;
    logic             win_ok;
    logic             win_miss;
    logic             active;
    logic             ready;
    logic             cfg_upd;
    logic [CFG_W-1:0] cfg;
    wire  [18:0]      fields;
    logic [CFG_W-1:0] model;
    int               n_fail = 0;
    int               tests_run = 0;
    int               cycles = 0;

    // undriven pin shows a toggling level, never the last driven one
    assign din = host_oe ? host_pin : (dout_oe ? dout : flip_q);

    rcp_host_model rcp_host_model_inst (
        .sclk_o      (sclk),
        .pin_o       (host_pin),
        .pin_oe_o    (host_oe),
        .pick_mute_o ()
    );

    rcp_config_port #(
        .STARTUP_CYC (STARTUP)
    ) rcp_config_port_inst (
        .ref_clk_i          (ref_clk),
        .reset_i            (reset),
        .sclk_i             (sclk),
        .din_i              (din),
        .dout_o             (dout),
        .dout_oe_o          (dout_oe),
        .power_down_input_i (pdown),
        .demod_data_i       (demod),
        .window_ok_i        (win_ok),
        .window_miss_i      (win_miss),
        .rx_active_o        (active),
        .rx_ready_o         (ready),
        .cfg_update_o       (cfg_upd),
        .config_word_o      (cfg),
        .desense_o          (fields[2:0]),
        .demod_bw_o         (fields[4:3]),
        .slice_level_o      (fields[6:5]),
        .bit_check_o        (fields[8:7]),
        .window_len_o       (fields[11:9]),
        .sleep_time_o       (fields[14:12]),
        .autopoll_o         (fields[15]),
        .high_bw_o          (fields[16]),
        .watchdog_en_o      (fields[17]),
        .rssi_offset_o      (fields[18])
    );

    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        flip_q <= ~flip_q;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [CFG_W-1:0] seen,
                         input logic [CFG_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [CFG_W-1:0] exp_fields(input logic [CFG_W-1:0] w);
        return {1'b0, w[19], ~w[18], w[16], w[15], w[14:0]};
    endfunction

    task automatic pulse(input bit miss);
        @(posedge ref_clk);
        #1;
        win_ok   = !miss;
        win_miss = miss;
        @(posedge ref_clk);
        #1;
        win_ok   = 1'b0;
        win_miss = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask

    task automatic session(input logic [CFG_W-1:0] w, input int n);
        logic [CFG_W-1:0] mask;
        logic [CFG_W-1:0] ef;
        mask  = (n >= CFG_W) ? '1 : CFG_W'((1 << n) - 1);
        model = (model & ~mask) | (w & mask);
        fork
            rcp_host_model_inst.send(w, n);
            begin
                @(posedge sclk);
                repeat (T1_CYC) @(negedge ref_clk);
                check("pin released", CFG_W'(dout_oe), '0);
                for (int k = 0; k < 3000 && cfg_upd !== 1'b1; k++) @(negedge ref_clk);
                check("commit pulse", CFG_W'(cfg_upd), CFG_W'(1));
                check("config word", cfg, model);
                ef = exp_fields(model);
                check("dsn bw", CFG_W'(fields[4:0]), CFG_W'(ef[4:0]));
                check("slice chk", CFG_W'(fields[8:5]), CFG_W'(ef[8:5]));
                check("win sleep", CFG_W'(fields[14:9]), CFG_W'(ef[14:9]));
                check("poll hbw", CFG_W'(fields[16:15]), CFG_W'(ef[16:15]));
                check("wdog rssi", CFG_W'(fields[18:17]), CFG_W'(ef[18:17]));
                check("pin driven", CFG_W'(dout_oe), CFG_W'(1));
            end
        join
        repeat (10) @(negedge ref_clk);
    endtask

    initial begin
        reset    = 1'b1;
        pdown    = 1'b1;
        demod    = 1'b0;
        win_ok   = 1'b0;
        win_miss = 1'b0;
        model    = CFG_RESET;
        void'($urandom(70));
        repeat (8) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("active at reset", CFG_W'(active), CFG_W'(0));
        check("cfg at reset", cfg, CFG_RESET);
        @(posedge ref_clk);
        #1;
        pdown = 1'b0;
        for (int k = 0; k < 20 && active !== 1'b1; k++) @(negedge ref_clk);
        check("active", CFG_W'(active), CFG_W'(1));
        repeat (STARTUP - 10) @(negedge ref_clk);
        check("early ready", CFG_W'(ready), CFG_W'(0));
        repeat (20) @(negedge ref_clk);
        check("ready", CFG_W'(ready), CFG_W'(1));
        @(posedge ref_clk);
        #1;
        demod = 1'b1;
        repeat (6) @(negedge ref_clk);
        check("data passes", CFG_W'(dout), CFG_W'(1));
        // corner words interleaved with short sessions that keep the upper bits
        session(20'h00000, 20);
        session(20'hFFFFF, 20);
        session(20'h00005, 3);
        session(20'hC0000, 20);
        session(20'h20000, 18);
        session(20'hFFFFF, 1);
        for (int r = 0; r < 10; r++) begin
            session(CFG_W'($urandom), 1 + ($urandom % 20));
        end
        // autopoll: data blanked until four good windows
        session(20'h4C760, 20);
        for (int p = 0; p < 3; p++) begin
            pulse(1'b0);
        end
        check("blanked", CFG_W'(dout), CFG_W'(0));
        pulse(1'b0);
        check("woken", CFG_W'(dout), CFG_W'(1));
        pulse(1'b1);
        check("miss blanks", CFG_W'(dout), CFG_W'(0));
        // wake again so that shutdown has live data to stop
        for (int q = 0; q < 4; q++) begin
            pulse(1'b0);
        end
        check("woken again", CFG_W'(dout), CFG_W'(1));
        @(posedge ref_clk);
        #1;
        pdown = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("stopped", CFG_W'(active), CFG_W'(0));
        check("stopped data", CFG_W'(dout), CFG_W'(0));
        // a reset in mid-run drops the programmed word
        @(posedge ref_clk);
        #1;
        reset = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("cfg after reset", cfg, CFG_RESET);
        check("oe after reset", CFG_W'(dout_oe), CFG_W'(1));
        summarize();
    end
endmodule

// file: hw/rcp_config_port.sv
// Two-wire configuration port, session sequencer and config field decode.
`timescale 1ns/1ps
module rcp_config_port
    import rcp_pkg::*;
#(
    parameter int STARTUP_CYC = STARTUP_CYC_DEF
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic             sclk_i,
    input  wire logic             din_i,
    output logic                  dout_o,
    output logic                  dout_oe_o,
    input  wire logic             power_down_input_i,
    input  wire logic             demod_data_i,
    input  wire logic             window_ok_i,
    input  wire logic             window_miss_i,
    output logic                  rx_active_o,
    output logic                  rx_ready_o,
    output logic                  cfg_update_o,
    output logic [CFG_W-1:0]      config_word_o,
    output logic [2:0]            desense_o,
    output logic [1:0]            demod_bw_o,
    output logic [1:0]            slice_level_o,
    output logic [1:0]            bit_check_o,
    output logic [2:0]            window_len_o,
    output logic [2:0]            sleep_time_o,
    output logic                  autopoll_o,
    output logic                  high_bw_o,
    output logic                  watchdog_en_o,
    output logic                  rssi_offset_o
);

    localparam int SU_W    = $clog2(STARTUP_CYC + 1);
    localparam int REL_LAT = 2;

    rcp_link_if lnk ();

    rcp_link_shift u_shift (
        .sclk_i (sclk_i),
        .din_i  (din_i),
        .lnk    (lnk.shifter)
    );

    // synchronisers for the pins and the link word
    logic              sclk_m_q;
    logic              sclk_s_q;
    logic              sclk_d_q;
    logic              din_m_q;
    logic              din_s_q;
    logic              din_d_q;
    logic              pd_m_q;
    logic              pd_s_q;
    logic              demod_m_q;
    logic              demod_s_q;
    logic [LINK_W-1:0] link_m_q;
    logic [LINK_W-1:0] link_s_q;

    rcp_state_t        st_q;
    logic [CNT_W-1:0]  edge_cnt_q;
    logic [CNT_W-1:0]  bits_n;
    logic [CNT_W-1:0]  last_bits_q;
    logic              commit;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              din_rise;
    logic              din_fall;

    logic [CFG_W-1:0]  receiver_config_word_q;
    logic [CFG_W-1:0]  receiver_config_word_d;
    logic              cfg_update_q;

    logic              shutdown_q;
    logic [SU_W-1:0]   su_cnt_q;
    logic              ready_q;
    logic [CHK_W-1:0]  ok_cnt_q;
    logic [CHK_W-1:0]  ok_need;
    logic              accept_q;
    logic              dout_q;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sclk_m_q  <= 1'b0;
            sclk_s_q  <= 1'b0;
            sclk_d_q  <= 1'b0;
            din_m_q   <= 1'b0;
            din_s_q   <= 1'b0;
            din_d_q   <= 1'b0;
            pd_m_q    <= 1'b1;
            pd_s_q    <= 1'b1;
            demod_m_q <= 1'b0;
            demod_s_q <= 1'b0;
        end else begin
            sclk_m_q  <= sclk_i;
            sclk_s_q  <= sclk_m_q;
            sclk_d_q  <= sclk_s_q;
            din_m_q   <= din_i;
            din_s_q   <= din_m_q;
            din_d_q   <= din_s_q;
            pd_m_q    <= power_down_input_i;
            pd_s_q    <= pd_m_q;
            demod_m_q <= demod_data_i;
            demod_s_q <= demod_m_q;
        end
    end

    // multi-bit sync is safe: the word is static long before the commit reads it
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            link_m_q <= '0;
            link_s_q <= '0;
        end else begin
            link_m_q <= lnk.word;
            link_s_q <= link_m_q;
        end
    end

    assign sclk_rise = sclk_s_q && !sclk_d_q;
    assign sclk_fall = !sclk_s_q && sclk_d_q;
    assign din_rise  = din_s_q && !din_d_q;
    assign din_fall  = !din_s_q && din_d_q;

    // session sequencer; the pin stays released from the first clock high
    // until the stop completes, so a stray clock pulse keeps it released until a later session's stop
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_q       <= ST_IDLE;
            edge_cnt_q <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (sclk_s_q) begin
                        st_q <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (!sclk_s_q) begin
                        st_q <= ST_PRIME;
                    end
                end
                ST_PRIME: begin
                    if (sclk_s_q) begin
                        st_q <= din_s_q ? ST_ARMED : ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    if (!sclk_s_q) begin
                        st_q <= ST_PRIME;
                    end else if (din_rise) begin
                        st_q <= ST_OPEN_HI;
                    end
                end
                ST_OPEN_HI: begin
                    if (!sclk_s_q) begin
                        st_q <= ST_PRIME;
                    end else if (din_fall) begin
                        st_q       <= ST_SHIFT;
                        edge_cnt_q <= '0;
                    end
                end
                ST_SHIFT: begin
                    if (sclk_rise && edge_cnt_q != CNT_W'(LINK_W)) begin
                        edge_cnt_q <= edge_cnt_q + CNT_W'(1);
                    end
                    // data only moves while the clock is low, except at a stop
                    if (sclk_s_q && sclk_d_q && din_rise) begin
                        st_q <= ST_STOP_HI;
                    end
                end
                ST_STOP_HI: begin
                    if (!sclk_s_q) begin
                        st_q <= ST_SHIFT;
                    end else if (din_fall) begin
                        st_q <= ST_STOP_LO;
                    end
                end
                ST_STOP_LO: begin
                    if (!sclk_s_q) begin
                        st_q <= ST_IDLE;
                    end else if (din_rise) begin
                        st_q <= ST_STOP_HI;
                    end
                end
            endcase
        end
    end

    assign commit = (st_q == ST_STOP_LO) && !sclk_s_q;

    // the stop's own clock rise shifts in one dummy bit at the bottom
    assign bits_n = (edge_cnt_q == '0) ? '0 : edge_cnt_q - CNT_W'(1);

    always_comb begin
        receiver_config_word_d = receiver_config_word_q;
        for (int i = 0; i < CFG_W; i++) begin
            if (CNT_W'(i) < bits_n) begin
                receiver_config_word_d[i] = link_s_q[i+1];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            receiver_config_word_q <= CFG_RESET;
            cfg_update_q           <= 1'b0;
            last_bits_q            <= '0;
        end else begin
            cfg_update_q <= commit;
            if (commit) begin
                receiver_config_word_q <= receiver_config_word_d;
                last_bits_q            <= bits_n;
            end
        end
    end

    // reset forces shutdown; the pin level is taken only after release
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            shutdown_q <= 1'b1;
        end else begin
            shutdown_q <= pd_s_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || shutdown_q) begin
            su_cnt_q <= '0;
            ready_q  <= 1'b0;
        end else if (!ready_q) begin
            if (su_cnt_q == SU_W'(STARTUP_CYC - 1)) begin
                ready_q <= 1'b1;
            end else begin
                su_cnt_q <= su_cnt_q + SU_W'(1);
            end
        end
    end

    // 2^code consecutive valid windows; a good window beats a miss
    assign ok_need = CHK_W'(1) << bit_check_o;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !ready_q) begin
            ok_cnt_q <= '0;
            accept_q <= 1'b0;
        end else if (window_ok_i) begin
            if (!accept_q) begin
                ok_cnt_q <= ok_cnt_q + CHK_W'(1);
                if (ok_cnt_q + CHK_W'(1) == ok_need) begin
                    accept_q <= 1'b1;
                end
            end
        end else if (window_miss_i) begin
            ok_cnt_q <= '0;
            accept_q <= 1'b0;
        end
    end

    // autopoll holds the pin low until the check passes, which is the wake
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            dout_q <= 1'b0;
        end else begin
            dout_q <= ready_q && (!autopoll_o || accept_q) && demod_s_q;
        end
    end

    assign dout_o        = dout_q;
    assign dout_oe_o     = (st_q == ST_IDLE) && !sclk_s_q;
    assign rx_active_o   = !shutdown_q;
    assign rx_ready_o    = ready_q;
    assign cfg_update_o  = cfg_update_q;
    assign config_word_o = receiver_config_word_q;

    assign desense_o     = receiver_config_word_q[DSN_LSB +: 3];
    assign demod_bw_o    = receiver_config_word_q[BW_LSB +: 2];
    assign slice_level_o = receiver_config_word_q[SLC_LSB +: 2];
    assign bit_check_o   = receiver_config_word_q[BCK_LSB +: 2];
    assign window_len_o  = receiver_config_word_q[WIN_LSB +: 3];
    assign sleep_time_o  = receiver_config_word_q[SLP_LSB +: 3];
    assign autopoll_o    = receiver_config_word_q[APOLL_BIT];
    assign high_bw_o     = receiver_config_word_q[HBW_BIT];
    assign watchdog_en_o = !receiver_config_word_q[WDOG_BIT];
    assign rssi_offset_o = receiver_config_word_q[RSSI_BIT];

    // checks
    default clocking chk_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    logic [CFG_W-1:0] link_word_w;
    logic             cfg_msb_w;
    assign link_word_w = link_s_q[CFG_W:1];
    assign cfg_msb_w   = receiver_config_word_q[CFG_W-1];

    chk_release_fast: assert property (
        $rose(sclk_i) && st_q == ST_IDLE |-> ##[1:REL_LAT] !dout_oe_o)
        else $error("data pin not released after clock rise");

    chk_held_released: assert property (
        st_q == ST_ARMED |-> !dout_oe_o throughout (st_q != ST_IDLE)[*3])
        else $error("data pin driven inside a session");

    chk_open_seq: assert property (
        st_q == ST_OPEN_HI && sclk_s_q && din_fall |=> st_q == ST_SHIFT && edge_cnt_q == '0)
        else $error("open sequence did not start shifting");

    chk_stop_return: assert property (
        st_q == ST_STOP_LO && !sclk_s_q |=> cfg_update_q ##0 dout_oe_o)
        else $error("stop did not commit and return the pin");

    chk_full_word: assert property (
        cfg_update_q && last_bits_q == CNT_W'(CFG_W) |->
            receiver_config_word_q == $past(link_word_w))
        else $error("full word not taken msb first");

    chk_keep_upper: assert property (
        cfg_update_q && last_bits_q < CNT_W'(CFG_W) |-> cfg_msb_w == $past(cfg_msb_w))
        else $error("unsent upper bit changed");

    chk_no_early_apply: assert property (
        st_q == ST_SHIFT |=> $stable(receiver_config_word_q))
        else $error("config changed before stop");

    chk_shutdown_gate: assert property (
        shutdown_q [*3] |-> !rx_active_o && !dout_o && !rx_ready_o)
        else $error("receiver active in shutdown");

    chk_reset_power_down_input: assert property (
        $fell(reset_i) |-> shutdown_q && receiver_config_word_q == CFG_RESET)
        else $error("reset did not leave shutdown with preset word");

    chk_autopoll_low: assert property (
        autopoll_o && !accept_q |=> !dout_o)
        else $error("autopoll pin not held low before wake");

    chk_four_windows: assert property (
        $rose(accept_q) && bit_check_o == BCK_4BITS |-> $past(ok_cnt_q) == CHK_W'(3))
        else $error("accept not after four windows");

    chk_startup_wait: assert property (
        $rose(ready_q) |-> $past(su_cnt_q) == SU_W'(STARTUP_CYC - 1))
        else $error("ready before startup wait");

    cov_full_session: cover property (cfg_update_q && last_bits_q == CNT_W'(CFG_W));
    cov_short_session: cover property (cfg_update_q && last_bits_q == CNT_W'(3));
    cov_autopoll_wake: cover property (autopoll_o && $rose(accept_q));
    cov_ready: cover property ($rose(rx_ready_o));

endmodule

// file: hw/rcp_link_shift.sv
// Serial clock domain shift register of the config port.
`timescale 1ns/1ps
module rcp_link_shift
    import rcp_pkg::*;
(
    input  wire logic   sclk_i,
    input  wire logic   din_i,
    rcp_link_if.shifter lnk
);

    logic [LINK_W-1:0] shift_q;

    // no reset: the core only reads this word after a stop, when it is static
    always_ff @(posedge sclk_i) begin
        shift_q <= {shift_q[LINK_W-2:0], din_i};
    end

    assign lnk.word = shift_q;

endmodule

// file: inc/rcp_link_if.sv
// Shift word carried from the serial clock domain to the core.
`timescale 1ns/1ps
interface rcp_link_if;
    import rcp_pkg::*;
    logic [LINK_W-1:0] word;
    modport shifter (output word);
    modport core    (input  word);
endinterface

// file: inc/rcp_pkg.sv
// Shared constants, field layout and state codes of the receiver serial config port.
package rcp_pkg;

    localparam int CFG_W      = 20;
    localparam int LINK_W     = CFG_W + 1;
    localparam int CNT_W      = 5;
    localparam int CHK_W      = 4;
    localparam logic [CFG_W-1:0] CFG_RESET = 20'h00000;

    // field positions inside the config word
    localparam int DSN_LSB    = 0;
    localparam int BW_LSB     = 3;
    localparam int SLC_LSB    = 5;
    localparam int BCK_LSB    = 7;
    localparam int WIN_LSB    = 9;
    localparam int SLP_LSB    = 12;
    localparam int APOLL_BIT  = 15;
    localparam int HBW_BIT    = 16;
    localparam int WDOG_BIT   = 18;
    localparam int RSSI_BIT   = 19;

    // field codes with a known meaning
    localparam logic [2:0] DSN_NONE   = 3'h0;
    localparam logic [1:0] BW_1712HZ  = 2'h0;
    localparam logic [1:0] SLC_50PCT  = 2'h3;
    localparam logic [1:0] BCK_4BITS  = 2'h2;
    localparam logic [2:0] WIN_433US  = 3'h3;
    localparam logic [2:0] SLP_160MS  = 3'h4;

    // timing
    localparam int CLK_MHZ         = 200;
    localparam int T1_MAX_NS       = 100;
    localparam int T1_CYC          = (T1_MAX_NS * CLK_MHZ) / 1000;
    localparam int STARTUP_US      = 1000;
    localparam int STARTUP_CYC_DEF = STARTUP_US * CLK_MHZ;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_ARMED   = 8'h02,
        ST_PRIME   = 8'h04,
        ST_OPEN    = 8'h08,
        ST_OPEN_HI = 8'h10,
        ST_SHIFT   = 8'h20,
        ST_STOP_HI = 8'h40,
        ST_STOP_LO = 8'h80
    } rcp_state_t;

endpackage
